// >>> e2e_parity_pkg.sv
// Shared constants, register map, field layout and helpers for the parity unit
package e2e_parity_pkg;

  // Data path width toward and from the switch core
  localparam int unsigned DWORD_W = 32;
  localparam int unsigned LEN_W   = 8;
  localparam int unsigned TALLY_W = 8;
  localparam int unsigned IDX_W   = 10;

  // Register byte addresses
  localparam logic [11:0] PARITY_ERROR_CONTROL_ADDR          = 12'h4d4;
  localparam logic [11:0] INTERNAL_ERROR_STATUS_ADDR         = 12'h4d8;
  localparam logic [11:0] INTERNAL_ERROR_REPORT_CONTROL_ADDR = 12'h4dc;
  localparam logic [11:0] INTERNAL_ERROR_COUNTER_ADDR        = 12'h4e0;
  localparam logic [11:0] INTERNAL_ERROR_IRQ_MASK_ADDR       = 12'h4f0;

  // Field positions in parity_error_control
  localparam int unsigned PARITY_CHECK_DISABLE_BIT     = 0;
  localparam int unsigned BAD_PARITY_INJECT_ENABLE_BIT = 1;
  localparam int unsigned MATCH_LEN_LO                 = 8;
  localparam int unsigned MATCH_LEN_HI                 = 15;
  // Field positions in status, report control, counter and mask
  localparam int unsigned PARITY_ERROR_FLAG_BIT        = 0;
  localparam int unsigned REPORT_SELECT_LO             = 0;
  localparam int unsigned REPORT_SELECT_HI             = 1;
  localparam int unsigned PARITY_ERROR_IRQ_ENABLE_BIT  = 2;
  localparam int unsigned TALLY_LO                     = 0;
  localparam int unsigned TALLY_HI                     = 7;
  localparam int unsigned IRQ_MASK_BIT                 = 0;

  // Header byte zero position inside the first double word
  localparam int unsigned HDR_LEN_LO = 0;
  localparam int unsigned HDR_LEN_HI = 7;

  // Error message kinds sent toward the root
  typedef enum logic [1:0] {
    REPORT_NONE     = 2'h0,
    REPORT_COR      = 2'h1,
    REPORT_NONFATAL = 2'h2,
    REPORT_FATAL    = 2'h3
  } report_sel_t;

  // Reset values, tally saturation limit and increment
  localparam report_sel_t          REPORT_SELECT_RESET = REPORT_NONFATAL;
  localparam logic [LEN_W-1:0]     MATCH_LEN_RESET     = 8'h00;
  localparam logic [TALLY_W-1:0]   TALLY_RESET         = 8'h00;
  localparam logic [TALLY_W-1:0]   TALLY_MAX           = 8'hff;
  localparam logic [TALLY_W-1:0]   TALLY_ONE           = 8'h01;
  localparam logic [DWORD_W-1:0]   RDATA_ZERO          = 32'h0000_0000;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Parity of one double word; odd selects odd parity
  function automatic logic parity_of(input logic [DWORD_W-1:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  // Word index of a byte address
  function automatic logic [IDX_W-1:0] word_idx(input logic [11:0] a);
    return a[11:2];
  endfunction

endpackage

// >>> egress_if.sv
// Egress double-word path between the register side and the parity generator
`timescale 1ns/1ps
interface egress_if;
  import e2e_parity_pkg::*;

  logic                 valid;
  logic                 sop;
  logic [DWORD_W-1:0]   data;
  logic                 inject_en;
  logic [LEN_W-1:0]     match_len;
  logic                 odd;
  logic                 out_valid;
  logic [DWORD_W-1:0]   out_data;
  logic                 out_parity;

  modport gen (
    input  valid, sop, data, inject_en, match_len, odd,
    output out_valid, out_data, out_parity
  );
  modport ctl (
    output valid, sop, data, inject_en, match_len, odd,
    input  out_valid, out_data, out_parity
  );
endinterface

// >>> egress_parity_gen.sv
// Parity generator with bad-parity injection on double words sent to the switch core
`timescale 1ns/1ps
module egress_parity_gen
  import e2e_parity_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Egress path
  egress_if.gen     eg
);

  typedef struct packed {
    logic               out_valid;
    logic [DWORD_W-1:0] out_data;
    logic               out_parity;
    logic               hit_hold;
  } gen_state_t;

  gen_state_t s;
  gen_state_t next_s;
  logic       hit_now;

  // Match decision taken on the first double word, held for the packet
  always_comb begin
    next_s = s;
    hit_now = s.hit_hold;
    if (eg.valid && eg.sop) begin
      hit_now = eg.inject_en && (eg.data[HDR_LEN_HI:HDR_LEN_LO] == eg.match_len); // R4
      next_s.hit_hold = hit_now;
    end
    next_s.out_valid = eg.valid;
    next_s.out_data  = eg.data;
    // Parity is always generated; injection only inverts it
    next_s.out_parity = parity_of(eg.data, eg.odd) ^ (eg.valid && hit_now); // R2 R3 R5
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign eg.out_valid  = s.out_valid;
  assign eg.out_data   = s.out_data;
  assign eg.out_parity = s.out_parity;

endmodule

// >>> port_e2e_parity_error_unit.sv
// Per-port end-to-end parity unit with AHB-Lite registers, reporting and interrupt
//
// What this block does
// R1: Disable bit set means no parity check, no flag, count or report.
// R2: Parity is always generated on every double word sent to the core.
// R3: Injection bit set inverts parity on every double word of matching packets.
// R4: A packet matches when header byte zero equals the match-length field.
// R5: Injection covers link-received and locally generated packets alike.
// R6: A detected error sets the status flag; writing one clears it.
// R7: Two-bit field picks none, correctable, nonfatal or fatal message; resets nonfatal.
// R8: Message goes out only when the status flag rises from zero.
// R9: Interrupt enable plus upstream enable makes each error request INTx or MSI.
// R10: Eight-bit tally counts each error and saturates at all ones.
// R11: Reading the tally returns its value and clears it.
// R12: Control, match length and tally survive soft reset; status and report do not.
`timescale 1ns/1ps
module port_e2e_parity_error_unit
  import e2e_parity_pkg::*;
#(
  parameter bit ODD_PARITY = 1'b0
)(
  // Clock and resets
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 soft_rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Packets toward the switch core, from link or from the port itself
  input  wire logic                 tx_valid,
  input  wire logic                 tx_sop,
  input  wire logic [DWORD_W-1:0]   tx_data,
  output logic                      core_tx_valid,
  output logic      [DWORD_W-1:0]   core_tx_data,
  output logic                      core_tx_parity,
  // Double words arriving from the switch core
  input  wire logic                 core_rx_valid,
  input  wire logic [DWORD_W-1:0]   core_rx_data,
  input  wire logic                 core_rx_parity,
  // Error message and interrupt request toward the root
  input  wire logic                 upstream_irq_en,
  output logic                      err_msg_valid,
  output logic      [1:0]           err_msg_type,
  output logic                      intx_msi_req,
  output logic                      irq
);

  // All register and reporting state
  typedef struct packed {
    logic               parity_check_disable;
    logic               bad_parity_inject_enable;
    logic [LEN_W-1:0]   match_len;
    logic               parity_error_flag;
    report_sel_t        report_select;
    logic               parity_error_irq_enable;
    logic [TALLY_W-1:0] parity_error_tally;
    logic               irq_mask;
    logic               wr_pend;
    logic [IDX_W-1:0]   wr_idx;
    logic [31:0]        rdata;
    logic               ready_out;
    logic               msg_valid;
    report_sel_t        msg_type;
    logic               intx_req;
    logic               irq_out;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;
  logic        detect;
  logic        addr_phase;
  logic [IDX_W-1:0] addr_idx;

  egress_if eg ();

  // Egress generator; its flops feed the core-side outputs directly
  egress_parity_gen u_gen (
    .clk  (clk),
    .nrst (nrst),
    .eg   (eg.gen)
  );

  // Egress control from the sticky control register
  assign eg.valid     = tx_valid;
  assign eg.sop       = tx_sop;
  assign eg.data      = tx_data;
  assign eg.inject_en = s.bad_parity_inject_enable; // R3
  assign eg.match_len = s.match_len;                // R4
  assign eg.odd       = ODD_PARITY;

  // Ingress check; the disable bit kills detection at its source
  assign detect = core_rx_valid && !s.parity_check_disable &&
                  (parity_of(core_rx_data, ODD_PARITY) != core_rx_parity); // R1

  // Address phase of a selected transfer
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_idx   = word_idx(haddr[11:0]);

  // Read mux of the register file
  function automatic logic [31:0] read_reg(input logic [IDX_W-1:0] idx,
                                           input unit_state_t st);
    logic [31:0] r;
    r = RDATA_ZERO;
    if (idx == word_idx(PARITY_ERROR_CONTROL_ADDR)) begin
      r[PARITY_CHECK_DISABLE_BIT]     = st.parity_check_disable;
      r[BAD_PARITY_INJECT_ENABLE_BIT] = st.bad_parity_inject_enable;
      r[MATCH_LEN_HI:MATCH_LEN_LO]    = st.match_len;
    end else if (idx == word_idx(INTERNAL_ERROR_STATUS_ADDR)) begin
      r[PARITY_ERROR_FLAG_BIT] = st.parity_error_flag;
    end else if (idx == word_idx(INTERNAL_ERROR_REPORT_CONTROL_ADDR)) begin
      r[REPORT_SELECT_HI:REPORT_SELECT_LO] = st.report_select;
      r[PARITY_ERROR_IRQ_ENABLE_BIT]       = st.parity_error_irq_enable;
    end else if (idx == word_idx(INTERNAL_ERROR_COUNTER_ADDR)) begin
      r[TALLY_HI:TALLY_LO] = st.parity_error_tally;
    end else if (idx == word_idx(INTERNAL_ERROR_IRQ_MASK_ADDR)) begin
      r[IRQ_MASK_BIT] = st.irq_mask;
    end
    return r;
  endfunction

  // Next-state logic: writes first, then hardware events, then reads
  always_comb begin
    next_s = s;
    next_s.msg_valid = 1'b0;
    next_s.intx_req  = 1'b0;
    next_s.wr_pend   = 1'b0;
    next_s.ready_out = 1'b1;

    // Data phase of a write; zero wait states, hwdata valid now
    if (s.wr_pend) begin
      if (s.wr_idx == word_idx(PARITY_ERROR_CONTROL_ADDR)) begin
        next_s.parity_check_disable     = hwdata[PARITY_CHECK_DISABLE_BIT];
        next_s.bad_parity_inject_enable = hwdata[BAD_PARITY_INJECT_ENABLE_BIT];
        next_s.match_len                = hwdata[MATCH_LEN_HI:MATCH_LEN_LO];
      end else if (s.wr_idx == word_idx(INTERNAL_ERROR_STATUS_ADDR)) begin
        if (hwdata[PARITY_ERROR_FLAG_BIT]) begin
          next_s.parity_error_flag = 1'b0; // R6
        end
      end else if (s.wr_idx == word_idx(INTERNAL_ERROR_REPORT_CONTROL_ADDR)) begin
        next_s.report_select =
          report_sel_t'(hwdata[REPORT_SELECT_HI:REPORT_SELECT_LO]); // R7
        next_s.parity_error_irq_enable = hwdata[PARITY_ERROR_IRQ_ENABLE_BIT];
      end else if (s.wr_idx == word_idx(INTERNAL_ERROR_IRQ_MASK_ADDR)) begin
        next_s.irq_mask = hwdata[IRQ_MASK_BIT];
      end
    end

    // Error event; applied after the clear so a same-cycle set wins
    if (detect) begin
      next_s.parity_error_flag = 1'b1; // R6
      // Only a rising flag reports, repeated errors stay quiet
      if (!s.parity_error_flag && (s.report_select != REPORT_NONE)) begin
        next_s.msg_valid = 1'b1; // R8
        next_s.msg_type  = s.report_select; // R7
      end
      if (s.parity_error_irq_enable && upstream_irq_en) begin
        next_s.intx_req = 1'b1; // R9
      end
      if (s.parity_error_tally != TALLY_MAX) begin
        next_s.parity_error_tally = s.parity_error_tally + TALLY_ONE; // R10
      end
    end

    // Address phase: writes wait for data, reads answer next cycle
    if (addr_phase) begin
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_idx  = addr_idx;
      end else begin
        // Read sees this cycle's write and event, so nothing is lost
        next_s.rdata = read_reg(addr_idx, next_s);
        if (addr_idx == word_idx(INTERNAL_ERROR_COUNTER_ADDR)) begin
          next_s.parity_error_tally = TALLY_RESET; // R11
        end
      end
    end

    // Soft reset returns only the non-sticky fields
    if (!soft_rst_n) begin
      next_s.parity_error_flag       = 1'b0; // R12
      next_s.report_select           = REPORT_SELECT_RESET; // R12
      next_s.parity_error_irq_enable = 1'b0;
      next_s.irq_mask                = 1'b0;
      next_s.msg_valid               = 1'b0;
      next_s.intx_req                = 1'b0;
    end

    // Level interrupt from the flag gated by its mask
    next_s.irq_out = next_s.parity_error_flag && next_s.irq_mask;
  end

  // State register; power-on reset returns every field to its reset value, sticky or not
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '{
        parity_check_disable:     1'b0,
        bad_parity_inject_enable: 1'b0,
        match_len:                MATCH_LEN_RESET,
        parity_error_flag:        1'b0,
        report_select:            REPORT_SELECT_RESET,
        parity_error_irq_enable:  1'b0,
        parity_error_tally:       TALLY_RESET,
        irq_mask:                 1'b0,
        wr_pend:                  1'b0,
        wr_idx:                   '0,
        rdata:                    RDATA_ZERO,
        ready_out:                1'b1,
        msg_valid:                1'b0,
        msg_type:                 REPORT_NONE,
        intx_req:                 1'b0,
        irq_out:                  1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops, except hresp which is tied to okay
  assign hrdata         = s.rdata;
  assign hreadyout      = s.ready_out;
  assign hresp          = HRESP_OKAY;
  assign core_tx_valid  = eg.out_valid;
  assign core_tx_data   = eg.out_data;
  assign core_tx_parity = eg.out_parity;
  assign err_msg_valid  = s.msg_valid;
  assign err_msg_type   = s.msg_type;
  assign intx_msi_req   = s.intx_req;
  assign irq            = s.irq_out;

endmodule

// >>> switch_core_model.sv
// Switch core stand-in that loops egress words back to the port
`timescale 1ns/1ps
module switch_core_model
  import e2e_parity_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Loopback control from the bench
  input  wire logic               loop_en,
  // Words from the port
  input  wire logic               core_tx_valid,
  input  wire logic [DWORD_W-1:0] core_tx_data,
  input  wire logic               core_tx_parity,
  // Words to the port
  output logic                    core_rx_valid,
  output logic      [DWORD_W-1:0] core_rx_data,
  output logic                    core_rx_parity
);
  logic live;

  assign live = loop_en && core_tx_valid;

  // Parity passes untouched so injected faults travel end to end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_rx_valid  <= 1'b0;
      core_rx_data   <= 32'h0000_0000;
      core_rx_parity <= 1'b0;
    end else begin
      core_rx_valid  <= live;
      // Idle lines toggle, so a stale word never looks live
      core_rx_data   <= live ? core_tx_data : ~core_rx_data;
      core_rx_parity <= live ? core_tx_parity : ~core_rx_parity;
    end
  end
endmodule

// >>> port_e2e_parity_error_unit_asserts.sv
// Port-level checks for the end-to-end parity unit
`timescale 1ns/1ps
module port_e2e_parity_error_unit_asserts
  import e2e_parity_pkg::*;
#(
  parameter bit ODD_PARITY = 1'b0
)(
  // Clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // Bus
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // Data paths
  input wire logic               tx_valid,
  input wire logic [DWORD_W-1:0] tx_data,
  input wire logic               core_tx_valid,
  input wire logic [DWORD_W-1:0] core_tx_data,
  input wire logic               core_rx_valid,
  input wire logic [DWORD_W-1:0] core_rx_data,
  input wire logic               core_rx_parity,
  // Reporting
  input wire logic               upstream_irq_en,
  input wire logic               err_msg_valid,
  input wire logic [1:0]         err_msg_type,
  input wire logic               intx_msi_req
);
  logic bad;
  logic rd_cnt;

  // Bad word seen from the core, and a tally read address phase
  assign bad = core_rx_valid && (core_rx_parity != ((^core_rx_data) ^ ODD_PARITY));
  assign rd_cnt = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
                  && haddr[11:0] == INTERNAL_ERROR_COUNTER_ADDR;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_tx_pass; tx_valid |=> core_tx_valid && core_tx_data == $past(tx_data); endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("egress word not passed on");
  property p_tx_idle; !tx_valid |=> !core_tx_valid; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("egress word from nowhere");
  property p_msg_cause; err_msg_valid |-> $past(bad); endproperty
  a_msg_cause: assert property (p_msg_cause) else $error("message without error");
  property p_msg_gap; err_msg_valid |=> !err_msg_valid; endproperty
  a_msg_gap: assert property (p_msg_gap) else $error("message repeated");
  property p_msg_type; err_msg_valid |-> err_msg_type != 2'h0; endproperty
  a_msg_type: assert property (p_msg_type) else $error("message of kind none");
  property p_req_cause; intx_msi_req |-> $past(bad && upstream_irq_en); endproperty
  a_req_cause: assert property (p_req_cause) else $error("interrupt request uncaused");
  property p_rcw; (rd_cnt && !bad) ##1 !bad ##1 (rd_cnt && !bad) |=> hrdata == RDATA_ZERO;
  endproperty
  a_rcw: assert property (p_rcw) else $error("tally not cleared by read");
  property p_bus_ok; hreadyout && hresp == HRESP_OKAY; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus slave not ready or not okay");
endmodule

bind port_e2e_parity_error_unit port_e2e_parity_error_unit_asserts #(.ODD_PARITY(ODD_PARITY))
  chk_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .tx_valid(tx_valid), .tx_data(tx_data), .core_tx_valid(core_tx_valid),
  .core_tx_data(core_tx_data), .core_rx_valid(core_rx_valid), .core_rx_data(core_rx_data),
  .core_rx_parity(core_rx_parity), .upstream_irq_en(upstream_irq_en),
  .err_msg_valid(err_msg_valid), .err_msg_type(err_msg_type), .intx_msi_req(intx_msi_req));

// >>> port_e2e_parity_error_unit_tb.sv
// Self-checking bench for the end-to-end parity unit
`timescale 1ns/1ps
module port_e2e_parity_error_unit_tb;
  import e2e_parity_pkg::*;
  localparam bit ODD = 1'b0;
  localparam logic [11:0] CT = PARITY_ERROR_CONTROL_ADDR;
  localparam logic [11:0] ST = INTERNAL_ERROR_STATUS_ADDR;
  localparam logic [11:0] RP = INTERNAL_ERROR_REPORT_CONTROL_ADDR;
  localparam logic [11:0] CN = INTERNAL_ERROR_COUNTER_ADDR;
  localparam logic [11:0] MK = INTERNAL_ERROR_IRQ_MASK_ADDR;
  logic        clk = 0, nrst = 0, soft_rst_n = 1, hsel = 0, hwrite = 0, tx_valid = 0;
  logic        tx_sop = 0, loop_en = 0, upstream_irq_en = 0, cur_bad = 0, bad_q = 0;
  logic [1:0]  htrans = 0, err_msg_type, last_type;
  logic [31:0] haddr = 0, hwdata = 0, tx_data = 0, hrdata, core_tx_data, core_rx_data, rd;
  logic        hreadyout, hresp, core_tx_valid, core_tx_parity, core_rx_valid;
  logic        core_rx_parity, err_msg_valid, intx_msi_req, irq;
  logic [7:0]  len;
  integer      seed = 32'hc530, fails = 0, n_tests = 0, cyc = 0, n_msg = 0, n_req = 0;

  port_e2e_parity_error_unit #(.ODD_PARITY(ODD)) dut (.clk(clk), .nrst(nrst),
    .soft_rst_n(soft_rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_valid(tx_valid), .tx_sop(tx_sop),
    .tx_data(tx_data), .core_tx_valid(core_tx_valid), .core_tx_data(core_tx_data),
    .core_tx_parity(core_tx_parity), .core_rx_valid(core_rx_valid),
    .core_rx_data(core_rx_data), .core_rx_parity(core_rx_parity),
    .upstream_irq_en(upstream_irq_en), .err_msg_valid(err_msg_valid),
    .err_msg_type(err_msg_type), .intx_msi_req(intx_msi_req), .irq(irq));
  switch_core_model model (.clk(clk), .nrst(nrst), .loop_en(loop_en),
    .core_tx_valid(core_tx_valid), .core_tx_data(core_tx_data),
    .core_tx_parity(core_tx_parity), .core_rx_valid(core_rx_valid),
    .core_rx_data(core_rx_data), .core_rx_parity(core_rx_parity));

  always #25 clk = ~clk;

  // Expected parity of an egress word
  function automatic logic epar(input logic [31:0] d, input logic b);
    return (^d) ^ b ^ ODD;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One single AHB-Lite transfer; hready is the slave's own hreadyout
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // Packet of n words, header byte zero l; b says whether parity must be bad
  task automatic pkt(input logic [7:0] l, input int n, input logic b);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      tx_valid <= 1'b1;
      tx_sop <= (i == 0);
      tx_data <= (i == 0) ? {r[31:8], l} : r;
      cur_bad <= b;
      @(posedge clk);
    end
    tx_valid <= 1'b0;
    tx_sop <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Egress parity monitor, pulse counters and hang guard
  always @(posedge clk) begin
    if (core_tx_valid === 1'b1) chk("egress parity", epar(core_tx_data, bad_q), core_tx_parity);
    bad_q <= tx_valid && cur_bad;
    if (err_msg_valid === 1'b1) n_msg++;
    if (err_msg_valid === 1'b1) last_type = err_msg_type;
    if (intx_msi_req === 1'b1) n_req++;
    cyc++;
    if (cyc == 6000) begin
      fails++;
      $display("[FAIL] timeout expected finish seen hang");
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc("control reset", CT, 32'h0);
    rdc("status reset", ST, 32'h0);
    rdc("report reset", RP, 32'h2);
    rdc("tally reset", CN, 32'h0);
    rdc("mask reset", MK, 32'h0);
    rdc("unmapped", 12'h4f8, 32'h0);
    // Matching and near-miss headers with injection on, link and local alike
    len = $random(seed);
    bus(1'b1, CT, {16'h0, len, 8'h02});
    for (int i = 0; i < 6; i++) pkt(i[0] ? len : len ^ (8'h1 << i), 2 + i, i[0]);
    // Matching header with injection off keeps good parity
    bus(1'b1, CT, {16'h0, len, 8'h00});
    pkt(len, 2, 1'b0);
    // Checking off: bad words looped back go unnoticed
    loop_en <= 1'b1;
    bus(1'b1, CT, {16'h0, len, 8'h03});
    pkt(len, 3, 1'b1);
    rdc("status disabled", ST, 32'h0);
    rdc("tally disabled", CN, 32'h0);
    chk("messages disabled", 0, n_msg);
    bus(1'b1, CT, {16'h0, len, 8'h02});
    // Each report kind; second error while flag set stays silent
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, RP, s);
      bus(1'b1, ST, 32'h1);
      n_msg = 0;
      pkt(len, 1, 1'b1);
      pkt(len, 2, 1'b1);
      chk("message count", s != 0, n_msg);
      if (s != 0) chk("message kind", s, last_type);
      bus(1'b1, ST, 32'h0);
      rdc("status after zero write", ST, 32'h1);
      bus(1'b1, ST, 32'h1);
      rdc("status after one write", ST, 32'h0);
      rdc("tally", CN, 32'h3);
    end
    // Interrupt raised, masked, cleared; request needs upstream enable
    bus(1'b1, MK, 32'h1);
    upstream_irq_en <= 1'b1;
    // Upstream enable alone must not request
    pkt(len, 1, 1'b1);
    chk("irq requests unenabled", 0, n_req);
    bus(1'b1, RP, 32'h6);
    n_req = 0;
    pkt(len, 2, 1'b1);
    chk("irq requests", 2, n_req);
    chk("irq level", 1, irq);
    bus(1'b1, MK, 32'h0);
    @(posedge clk);
    chk("irq masked", 0, irq);
    bus(1'b1, MK, 32'h1);
    bus(1'b1, ST, 32'h1);
    @(posedge clk);
    chk("irq cleared", 0, irq);
    upstream_irq_en <= 1'b0;
    pkt(len, 1, 1'b1);
    chk("irq requests gated", 2, n_req);
    // Saturation, then back-to-back reads clear
    rdc("tally before", CN, 32'h4);
    pkt(len, 300, 1'b1);
    rdc("tally saturated", CN, 32'hff);
    rdc("tally read clear", CN, 32'h0);
    // Soft reset keeps sticky fields only
    pkt(len, 1, 1'b1);
    bus(1'b1, RP, 32'h3);
    soft_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    soft_rst_n <= 1'b1;
    @(posedge clk);
    rdc("control sticky", CT, {16'h0, len, 8'h02});
    rdc("status soft", ST, 32'h0);
    rdc("report soft", RP, 32'h2);
    rdc("tally sticky", CN, 32'h1);
    give_verdict();
  end
endmodule
